//--- core/bit_skip_call_clear_exec.sv
// Execute logic for bit set, toggle, bit test skip, in-page call and register clear
`timescale 1ns/1ns
`default_nettype none
`include "bit_exec_regs.svh"

module bit_skip_call_clear_exec
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] mem_rdata_in,
    output logic instr_take_out,
    output logic [1:0] phase_out,
    output bit_exec_pkg::mem_req_s mem_out,
    output bit_exec_pkg::flow_s flow_out,
    output logic working_register_wr_out,
    output logic [7:0] working_register_data_out,
    output logic flush_out,
    output logic done_out,
    output logic busy_out
);
    bit_exec_pkg::state_s state_reg;
    bit_exec_pkg::state_s state_next;

    // Classify one instruction word; used only at decode in Q1
    function automatic bit_exec_pkg::op_e decode_op(input logic [15:0] w);
        decode_op = bit_exec_pkg::OP_NONE;
        if (w[15:13] == `CALL_TOP)
            decode_op = bit_exec_pkg::OP_CALL;
        else if (w[15:12] == `OPC_HI_SET && !w[11])
            decode_op = bit_exec_pkg::OP_SET;
        else if (w[15:12] == `OPC_HI_TEST)
            decode_op = w[11] ? bit_exec_pkg::OP_SKIP_ZERO : bit_exec_pkg::OP_SKIP_ONE;
        else if (w[15:12] == `OPC_HI_TOGGLE && w[11])
            decode_op = bit_exec_pkg::OP_TOGGLE;
        else if (w[15:12] == `OPC_HI_CLEAR && w[11:9] == `CLEAR_SUB)
            decode_op = bit_exec_pkg::OP_CLEAR;
    endfunction : decode_op

    // One-hot mask of the selected bit
    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = 8'h01 << b;
    endfunction : bit_mask

    // Next-state logic: a quarter-cycle phase counter drives each instruction
    always_comb
    begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.mem.rd = 1'b0;
        state_next.mem.wr = 1'b0;
        state_next.flow.push = 1'b0;
        state_next.flow.pc_load = 1'b0;
        state_next.flow.latch_load = 1'b0;
        state_next.w_wr = 1'b0;
        state_next.flush = 1'b0;
        // Phase advances every clock; only an empty decode slot holds it
        state_next.phase = state_reg.phase + 2'h1;
        case (state_reg.st)
            bit_exec_pkg::ST_EXEC:
            begin
                case (state_reg.phase)
                    `PH_Q1:
                    begin
                        // Decode; a word we do not own still costs one cycle of NOP
                        if (instr_valid_in)
                        begin
                            state_next.instr = instr_in;
                            state_next.op = decode_op(instr_in);
                        end
                        else
                        begin
                            // Idle decode slot: hold the phase so no cycle is spent
                            state_next.op = bit_exec_pkg::OP_NONE;
                            state_next.phase = `PH_Q1;
                        end
                    end
                    `PH_Q2:
                    begin
                        // Address latched for every word; only owned operations read it
                        state_next.mem.addr = state_reg.instr[7:0];
                        if (state_reg.op == bit_exec_pkg::OP_CALL)
                        begin
                            // Return address pushed before the counter moves
                            state_next.flow.push = 1'b1;
                            state_next.flow.push_data = pc_in + `PC_STEP;
                        end
                        else if (state_reg.op != bit_exec_pkg::OP_NONE)
                            state_next.mem.rd = 1'b1;
                    end
                    `PH_Q3:
                    begin
                        // Modify the byte read in Q2; flags are never touched here
                        case (state_reg.op)
                            bit_exec_pkg::OP_SET:
                                state_next.data = mem_rdata_in | bit_mask(state_reg.instr[10:8]);
                            bit_exec_pkg::OP_TOGGLE:
                                state_next.data = mem_rdata_in ^ bit_mask(state_reg.instr[10:8]);
                            bit_exec_pkg::OP_CLEAR:
                                state_next.data = `ZERO_BYTE;
                            default:
                                state_next.data = mem_rdata_in;
                        endcase
                        // Skip decision uses the same byte, so test and modify never see different data
                        state_next.cond = |(mem_rdata_in & bit_mask(state_reg.instr[10:8]));
                    end
                    `PH_Q4:
                    begin
                        state_next.done = 1'b1;
                        case (state_reg.op)
                            // Write-back in the last quarter, after the byte was modified
                            bit_exec_pkg::OP_SET, bit_exec_pkg::OP_TOGGLE:
                            begin
                                state_next.mem.wr = 1'b1;
                                state_next.mem.wdata = state_reg.data;
                            end
                            bit_exec_pkg::OP_CLEAR:
                            begin
                                state_next.mem.wr = 1'b1;
                                state_next.mem.wdata = state_reg.data;
                                state_next.w_wr = !state_reg.instr[8];
                                state_next.w_data = `ZERO_BYTE;
                            end
                            bit_exec_pkg::OP_SKIP_ZERO:
                            begin
                                state_next.flush = !state_reg.cond;
                                state_next.st = state_reg.cond ? bit_exec_pkg::ST_EXEC : bit_exec_pkg::ST_FLUSH;
                            end
                            bit_exec_pkg::OP_SKIP_ONE:
                            begin
                                state_next.flush = state_reg.cond;
                                state_next.st = state_reg.cond ? bit_exec_pkg::ST_FLUSH : bit_exec_pkg::ST_EXEC;
                            end
                            bit_exec_pkg::OP_CALL:
                            begin
                                // Upper three counter bits stay, so the target is page-local
                                state_next.flow.pc_load = 1'b1;
                                state_next.flow.pc_data = {pc_in[15:`PC_PAGE_LSB], state_reg.instr[12:0]};
                                state_next.flow.latch_load = 1'b1;
                                // Page number on top, upper literal bits below
                                state_next.flow.latch_data = {pc_in[15:`PC_PAGE_LSB],
                                    state_reg.instr[12:`LIT_HI_LSB]};
                                state_next.flush = 1'b1;
                                state_next.st = bit_exec_pkg::ST_FLUSH;
                            end
                            default:
                            begin
                                // Unowned words end here with only the done pulse
                            end
                        endcase
                    end
                    default:
                    begin
                        // Two-bit phase has no other codes
                    end
                endcase
            end
            bit_exec_pkg::ST_FLUSH:
            begin
                // Whole no-operation cycle while the prefetched word is dropped
                state_next.op = bit_exec_pkg::OP_NONE;
                // Take stays low throughout, so the discarded word is never decoded
                if (state_reg.phase == `PH_Q4)
                begin
                    state_next.done = 1'b1;
                    state_next.st = bit_exec_pkg::ST_EXEC;
                end
            end
            default:
            begin
                // Unused state code: fall back to a clean decode slot
                state_next.st = bit_exec_pkg::ST_EXEC;
                state_next.phase = `PH_Q1;
            end
        endcase
    end

    // State register with synchronous active-low reset
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            // Clearing the whole struct drops every pulse, so nothing writes after reset
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register; take and busy are the decoded terms
    // Pulses last one clock; addresses and data hold until the next overwrite
    assign instr_take_out = (state_reg.st == bit_exec_pkg::ST_EXEC) && (state_reg.phase == `PH_Q1);
    assign phase_out = state_reg.phase;
    assign mem_out = state_reg.mem;
    assign flow_out = state_reg.flow;
    assign working_register_wr_out = state_reg.w_wr;
    assign working_register_data_out = state_reg.w_data;
    assign flush_out = state_reg.flush;
    assign done_out = state_reg.done;
    assign busy_out = (state_reg.st == bit_exec_pkg::ST_FLUSH);
endmodule : bit_skip_call_clear_exec
`default_nettype wire

//--- core/bit_exec_regs.svh
// Constants for the bit, skip, call and clear execute block
`ifndef BIT_EXEC_REGS_SVH
`define BIT_EXEC_REGS_SVH
`define OPC_HI_SET 4'h8
`define OPC_HI_TEST 4'h9
`define OPC_HI_TOGGLE 4'h3
`define OPC_HI_CLEAR 4'h2
`define CLEAR_SUB 3'h4
`define CALL_TOP 3'h7
`define PC_PAGE_LSB 13
`define LIT_HI_LSB 8
`define ZERO_BYTE 8'h00
`define PC_STEP 16'h0001
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3
`endif

//--- core/bit_exec_pkg.sv
// Types for the bit, skip, call and clear execute block
`default_nettype none
package bit_exec_pkg;
    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_SET = 3'b001,
        OP_TOGGLE = 3'b010,
        OP_CLEAR = 3'b011,
        OP_SKIP_ZERO = 3'b100,
        OP_SKIP_ONE = 3'b101,
        OP_CALL = 3'b110
    } op_e;

    typedef enum logic [1:0]
    {
        ST_EXEC = 2'b00,
        ST_FLUSH = 2'b01
    } state_e;

    // Data memory request toward the register file
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    // Program counter, stack and latch update toward the core
    typedef struct packed {
        logic push;
        logic [15:0] push_data;
        logic pc_load;
        logic [15:0] pc_data;
        logic latch_load;
        logic [7:0] latch_data;
    } flow_s;

    typedef struct packed {
        state_e st;
        logic [1:0] phase;
        op_e op;
        logic [15:0] instr;
        logic [7:0] data;
        logic cond;
        logic done;
        logic flush;
        mem_req_s mem;
        flow_s flow;
        logic w_wr;
        logic [7:0] w_data;
    } state_s;
endpackage : bit_exec_pkg
`default_nettype wire

//--- sim/bit_exec_checker.sv
// Concurrent checks on the ports of the execute block
`timescale 1ns/1ns
`default_nettype none
module bit_exec_checker
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] pc_in,
    input wire logic instr_take_out,
    input wire bit_exec_pkg::mem_req_s mem_out,
    input wire bit_exec_pkg::flow_s flow_out,
    input wire logic working_register_wr_out,
    input wire logic [7:0] working_register_data_out,
    input wire logic flush_out,
    input wire logic done_out,
    input wire logic busy_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Write-back of a modified byte follows its read by two cycles at the same place
    chk_read_write: assert property (mem_out.wr |-> $past(mem_out.rd, 2)
        && mem_out.addr == $past(mem_out.addr, 2))
        else $error("write not preceded by read of same address");
    chk_skip_flush: assert property (flush_out |-> busy_out && done_out)
        else $error("flush outside an ending cycle");
    // The inserted no-operation lasts one full instruction cycle
    chk_nop_length: assert property ($rose(busy_out) |-> busy_out[*4] ##1 (!busy_out && done_out))
        else $error("no-operation cycle has wrong length");
    chk_busy_take: assert property (busy_out |-> !instr_take_out && !mem_out.rd && !mem_out.wr
        && !flow_out.push && !working_register_wr_out)
        else $error("work done during no-operation cycle");
    chk_push_ret: assert property (flow_out.push |-> flow_out.push_data == pc_in + 16'h0001
        ##2 flow_out.pc_load)
        else $error("return address or load timing wrong");
    chk_call_page: assert property (flow_out.pc_load |-> flow_out.pc_data[15:13] == pc_in[15:13]
        && flush_out)
        else $error("call left the current page");
    chk_latch_map: assert property (flow_out.latch_load |-> flow_out.latch_data ==
        {flow_out.pc_data[15:13], flow_out.pc_data[12:8]})
        else $error("high latch bits misplaced");
    chk_working_register_clear: assert property (working_register_wr_out |-> working_register_data_out == 8'h00
        && mem_out.wr && mem_out.wdata == 8'h00)
        else $error("working register clear not paired with cleared write");
endmodule : bit_exec_checker
`default_nettype wire

//--- sim/data_mem_model.sv
// Behavioural data memory answering the execute block
`timescale 1ns/1ns
`default_nettype none
module data_mem_model
(
    input wire logic clk_in,
    input wire bit_exec_pkg::mem_req_s mem_in,
    output logic [7:0] rdata_out
);
    logic [7:0] arr [256];
    logic rd_reg = 1'b0;

    // Data valid in the read pulse and the cycle after; otherwise inverted so stale values never match
    always_comb rdata_out = (mem_in.rd || rd_reg) ? arr[mem_in.addr] : ~arr[mem_in.addr];

    // Plain always: the bench preloads bytes hierarchically
    always @(posedge clk_in)
    begin
        rd_reg <= mem_in.rd;
        if (mem_in.wr) arr[mem_in.addr] <= mem_in.wdata;
    end
endmodule : data_mem_model
`default_nettype wire

//--- sim/bit_skip_call_clear_exec_tb.sv
// Self-checking bench for the bit, skip, call and clear execute block
`timescale 1ns/1ns
`default_nettype none
module bit_skip_call_clear_exec_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [15:0] pc_in = 16'h0000;
    logic [7:0] mem_rdata_in;
    logic instr_take_out;
    logic [1:0] phase_out;
    bit_exec_pkg::mem_req_s mem_out;
    bit_exec_pkg::flow_s flow_out;
    logic working_register_wr_out;
    logic [7:0] working_register_data_out;
    logic flush_out;
    logic done_out;
    logic busy_out;
    int err_count = 0;
    int n_tests = 0;

    bit_skip_call_clear_exec uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .pc_in(pc_in), .mem_rdata_in(mem_rdata_in), .instr_take_out(instr_take_out),
        .phase_out(phase_out), .mem_out(mem_out), .flow_out(flow_out),
        .working_register_wr_out(working_register_wr_out),
        .working_register_data_out(working_register_data_out), .flush_out(flush_out), .done_out(done_out),
        .busy_out(busy_out));
    data_mem_model mem_i (.clk_in(clk_in), .mem_in(mem_out), .rdata_out(mem_rdata_in));

    // Free-running 8 ns clock
    initial
    begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic close_out;
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Write flag and byte expected from the write-back
    function automatic logic [8:0] exp_mem(input logic [15:0] ins, input logic [7:0] old);
        logic [7:0] m;
        m = 8'h01 << ins[10:8];
        if (ins[15:11] == 5'h10) return {1'b1, old | m};
        if (ins[15:11] == 5'h07) return {1'b1, old ^ m};
        if (ins[15:9] == 7'h14) return 9'h100;
        return 9'h000;
    endfunction : exp_mem

    // Skip when the tested bit differs from the polarity field
    function automatic logic exp_skip(input logic [15:0] ins, input logic [7:0] old);
        return (ins[15:12] == 4'h9) && (old[ins[10:8]] != ins[11]);
    endfunction : exp_skip

    // One instruction: present it, record the write, flush, clear and flow pulses until the next take
    task automatic run(input logic [15:0] ins, input logic [15:0] pc, input logic [7:0] old);
        logic [8:0] sm;
        logic sf;
        logic sw;
        logic [39:0] sc;
        logic cl;
        int n;
        cl = ins[15:13] == 3'h7;
        sm = 9'h000;
        sf = 1'b0;
        sw = 1'b0;
        sc = 40'h0;
        n = 0;
        instr_in = ins;
        pc_in = pc;
        instr_valid_in = 1'b1;
        do
        begin
            @(posedge clk_in);
            #1;
            n++;
            // Drop valid and preload after the take edge, once the previous write-back has landed
            if (n == 1)
            begin
                instr_valid_in = 1'b0;
                mem_i.arr[ins[7:0]] = old;
            end
            check(phase_out, n % 4);
            if (mem_out.wr) sm = {1'b1, mem_out.wdata};
            sf |= flush_out;
            sw |= working_register_wr_out;
            if (flow_out.push) sc[39:24] = flow_out.push_data;
            if (flow_out.pc_load) sc[23:8] = flow_out.pc_data;
            if (flow_out.latch_load) sc[7:0] = flow_out.latch_data;
        end
        while (!instr_take_out && n < 20);
        check(done_out, 1'b1);
        check(n, (exp_skip(ins, old) || cl) ? 8 : 4);
        check(sf, exp_skip(ins, old) || cl);
        check(sm, exp_mem(ins, old));
        check(sw, ins[15:8] == 8'h28);
        check(sc[39:8], cl ? {pc + 16'h0001, pc[15:13], ins[12:0]} : 32'h0);
        check(sc[7:0], cl ? {pc[15:13], ins[12:8]} : 8'h00);
    endtask : run

    // Corner cases first, then random mix of every opcode and a non-decoded word
    initial
    begin
        logic [15:0] w;
        int k;
        void'($urandom(32'hf38a));
        repeat (4) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        run(16'h8fff, 16'h1234, 8'h7f);
        run(16'h3f00, 16'h0000, 8'hff);
        run(16'h2800, 16'h0000, 8'h5a);
        run(16'h2900, 16'h0000, 8'h5a);
        run(16'hffff, 16'he000, 8'h00);
        run(16'h9900, 16'h0000, 8'h00);
        run(16'h9100, 16'h0000, 8'h02);
        repeat (200)
        begin
            k = $urandom_range(6);
            w = 16'($urandom);
            case (k)
                0: w[15:11] = 5'h10;
                1: w[15:11] = 5'h07;
                2: w[15:9] = 7'h14;
                3: w[15:12] = 4'h9;
                4: w[15:13] = 3'h7;
                5: w[15:11] = 5'h06;
                default: w[15:12] = 4'h9;
            endcase
            run(w, 16'($urandom), 8'($urandom));
        end
        close_out();
    end

    // Hang guard sized well above 207 instructions of at most 8 clocks
    initial
    begin
        #(8 * 5000);
        err_count++;
        close_out();
    end
endmodule : bit_skip_call_clear_exec_tb

bind bit_skip_call_clear_exec bit_exec_checker chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .pc_in(pc_in),
    .instr_take_out(instr_take_out), .mem_out(mem_out), .flow_out(flow_out),
    .working_register_wr_out(working_register_wr_out), .working_register_data_out(working_register_data_out),
    .flush_out(flush_out), .done_out(done_out), .busy_out(busy_out));
`default_nettype wire
